// ===== hw/pwm_fault_pkg.sv
// Package of register map, field positions and reset values for the two-channel PWM block
package pwm_fault_pkg;
  // Register offsets (chosen map, byte-wide registers)
  localparam logic [3:0] ADDR_DUTY0_HIGH = 4'h0;
  localparam logic [3:0] ADDR_DUTY0_LOW = 4'h1;
  localparam logic [3:0] ADDR_DUTY1_HIGH = 4'h2;
  localparam logic [3:0] ADDR_DUTY1_LOW = 4'h3;
  localparam logic [3:0] ADDR_MOD_HIGH = 4'h4;
  localparam logic [3:0] ADDR_MOD_LOW = 4'h5;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h6;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h7;
  localparam logic [3:0] ADDR_FAULT_MAP = 4'h8;
  localparam logic [3:0] ADDR_FAULT_CTRL = 4'h9;
  localparam logic [3:0] ADDR_FAULT_STAT = 4'ha;
  localparam logic [3:0] ADDR_FAULT_ACK = 4'hb;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'hc;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'hd;
  // Control register one fields
  localparam int CTL1_FAULT_LOCATION_SELECT_BIT = 7;
  localparam int CTL1_RIRQ_BIT = 5;
  localparam int CTL1_RFLAG_BIT = 4;
  localparam int CTL1_LOAD_OK_BIT = 1;
  localparam int CTL1_EN_BIT = 0;
  // Control register two fields
  localparam int CTL2_LDFQ_LSB = 6;
  localparam int CTL2_SOFT_DISABLE_CH1_BIT = 5;
  localparam int CTL2_SOFT_DISABLE_CH0_BIT = 4;
  localparam int CTL2_POLARITY_CH1_BIT = 3;
  localparam int CTL2_POLARITY_CH0_BIT = 2;
  localparam int CTL2_PRSC_LSB = 0;
  // Fault registers fields
  localparam int MAP_CH1_BIT = 1;
  localparam int MAP_CH0_BIT = 0;
  localparam int FCTL_IRQ_BIT = 1;
  localparam int FCTL_MODE_BIT = 0;
  localparam int FSTAT_LEVEL_BIT = 1;
  localparam int FSTAT_FLAG_BIT = 0;
  localparam int FACK_BIT = 0;
  // Reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] FAULT_MAP_RESET = 8'h00;
  localparam logic [7:0] FAULT_CTRL_RESET = 8'h00;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [11:0] MOD_RESET = 12'h000;
  localparam int NUM_CH = 2;
endpackage

// ===== hw/pwm_byte_store.sv
// Small byte store holding the software-written duty and modulus buffers
`timescale 1ns/10ps
module pwm_byte_store (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [2:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic [47:0] all_out
);
  logic [7:0] mem_q [0:5];
  logic [7:0] rd_q;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 6; i++) begin
        mem_q[i] <= 8'h00;
      end
      rd_q <= 8'h00;
    end else begin
      if (wr_en_in && wr_addr_in < 3'h6) begin
        mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_q <= (rd_addr_in < 3'h6) ? mem_q[rd_addr_in] : 8'h00;
    end
  end

  assign rd_data_out = rd_q;
  assign all_out = {mem_q[5], mem_q[4], mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
endmodule // pwm_byte_store

// ===== hw/pwm_fault_top.sv
// Two-channel edge-aligned PWM generator with fault input and byte register port
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// R1: Each channel holds signed 16-bit duty value
// R2: Duty zero or negative keeps channel inactive
// R3: Duty at or above modulus keeps active
// R4: Reads return buffers, not active copies
// R5: Location bit picks port B bit 2/7
// R6: Reload interrupt while flag and enable set
// R7: Reload flag sets every reload cycle
// R8: Flag clear needs read then write zero
// R9: Load-ok set by read-0-write-1, auto-clears
// R10: Load-ok commits prescale, modulus, duty at reload
// R11: Enable clear disables, outputs high impedance
// R12: Reload every 1, 2, 4, 8 cycles
// R13: Load frequency applies after current load cycle
// R14: Software disable bit turns off pin
// R15: Polarity bit selects active-high or active-low
// R16: Prescaler divides bus clock 1/2/4/8
// R17: Fault map accepts only first write
// R18: Map bit lets fault disable channel
// R19: Fault irq enable gates only interrupt
// R20: Mode bit selects automatic or manual
// R21: Status bit shows fault input level
// R22: Fault flag sets on rise, ack clears
// R23: Automatic: re-enable when low at cycle start
// R24: Manual: re-enable after ack and low input
// R25: Fault interrupt latch cleared by ack/enable/reset
// R26: Twelve-bit modulus sets counter period
// R27: Active while counter below duty value
module pwm_fault_top
  import pwm_fault_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic port_b_bit2_in,
  input wire logic port_b_bit7_in,
  output logic [1:0] pwm_out,
  output logic [1:0] pwm_oe_n_out,
  output logic reload_irq_out,
  output logic fault_irq_out
);
  // ****************************************
  // Registers
  // ****************************************
  logic fault_location_select_q, reload_irq_enable_q, reload_flag_q, load_ok_q, generator_enable_q;
  logic [7:0] ctrl_two_q;
  logic [1:0] fault_map_q;
  logic map_written_q;
  logic fault_irq_enable_q, fault_reenable_mode_q;
  logic fault_event_flag_q, fault_irq_latch_q, fault_prev_q;
  logic flag_read_armed_q, load_ok_read_zero_q;
  logic [1:0] prescale_act_q, load_freq_act_q;
  logic [11:0] mod_act_q;
  logic [15:0] duty_act_q [NUM_CH];
  logic [11:0] count_q;
  logic [2:0] presc_cnt_q, load_cnt_q;
  logic [1:0] fault_block_q, soft_block_q;
  logic [1:0] pwm_q, oe_n_q;
  logic [7:0] rdata_q;
  logic reload_irq_q, fault_irq_q, count_low_latch_sel_q;
  logic [7:0] count_low_latch_q;

  // ****************************************
  // Buffer memory and decode
  // ****************************************
  logic [47:0] buf_all;
  // Duty and modulus bytes live in the byte store; everything else is decoded below
  wire buf_wr = wr_in && (addr_in <= ADDR_MOD_LOW);
  pwm_byte_store u_store (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .wr_en_in(buf_wr),
    .wr_addr_in(addr_in[2:0]),
    .wr_data_in(wdata_in),
    .rd_addr_in(addr_in[2:0]),
    .rd_data_out(),
    .all_out(buf_all)
  );
  wire [15:0] duty_buf0 = {buf_all[7:0], buf_all[15:8]}; // R1
  wire [15:0] duty_buf1 = {buf_all[23:16], buf_all[31:24]};
  wire [11:0] mod_buf = {buf_all[35:32], buf_all[47:40]};

  wire wr_ctl1 = wr_in && addr_in == ADDR_CTRL_ONE;
  wire rd_ctl1 = rd_in && addr_in == ADDR_CTRL_ONE;
  wire wr_ctl2 = wr_in && addr_in == ADDR_CTRL_TWO;
  wire wr_map = wr_in && addr_in == ADDR_FAULT_MAP;
  wire wr_fctl = wr_in && addr_in == ADDR_FAULT_CTRL;
  wire wr_ack = wr_in && addr_in == ADDR_FAULT_ACK && wdata_in[FACK_BIT]; // R22

  // Fault source; treated as synchronous to clock_in
  wire fault_level = fault_location_select_q ? port_b_bit2_in : port_b_bit7_in; // R5
  // Moving the fault location onto a high pin reads as a rising edge; acknowledge after a move
  wire fault_rise = fault_level && !fault_prev_q;

  // ****************************************
  // Counter, prescaler and reload timing
  // ****************************************
  wire [2:0] presc_max = 3'((4'h1 << prescale_act_q) - 4'h1); // R16
  wire tick = generator_enable_q && presc_cnt_q == presc_max;
  wire cycle_end = tick && (count_q >= mod_act_q - 12'h001); // R26
  wire [2:0] load_max = 3'((4'h1 << load_freq_act_q) - 4'h1); // R12
  wire enable_rise = wr_ctl1 && wdata_in[CTL1_EN_BIT] && !generator_enable_q;
  wire reload = (cycle_end && load_cnt_q == load_max) || enable_rise;
  // A load-ok in the enabling write commits at once, so the first period uses fresh values
  wire commit = reload && (load_ok_q || (enable_rise && wdata_in[CTL1_LOAD_OK_BIT] && load_ok_read_zero_q));
  wire cycle_start = cycle_end || enable_rise;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      presc_cnt_q <= 3'h0;
      count_q <= 12'h000;
      load_cnt_q <= 3'h0;
    end else if (!generator_enable_q && !enable_rise) begin
      presc_cnt_q <= 3'h0;
      count_q <= 12'h000;
      load_cnt_q <= 3'h0;
    end else if (enable_rise) begin
      presc_cnt_q <= 3'h0;
      count_q <= 12'h000;
      load_cnt_q <= 3'h0;
    end else begin
      // The prescaler restarts with each tick, so a new divisor never splits one
      presc_cnt_q <= tick ? 3'h0 : presc_cnt_q + 3'h1;
      if (tick) begin
        count_q <= cycle_end ? 12'h000 : count_q + 12'h001;
      end
      if (cycle_end) begin
        load_cnt_q <= (load_cnt_q == load_max) ? 3'h0 : load_cnt_q + 3'h1;
      end
    end
  end

  // Active copies: load frequency follows each load cycle, the rest waits for load-ok
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prescale_act_q <= 2'h0;
      load_freq_act_q <= 2'h0;
      mod_act_q <= MOD_RESET;
      duty_act_q[0] <= DUTY_RESET;
      duty_act_q[1] <= DUTY_RESET;
    end else begin
      if (reload) begin
        load_freq_act_q <= ctrl_two_q[CTL2_LDFQ_LSB +: 2]; // R13
      end
      if (commit) begin
        prescale_act_q <= ctrl_two_q[CTL2_PRSC_LSB +: 2]; // R10
        mod_act_q <= mod_buf;
        duty_act_q[0] <= duty_buf0;
        duty_act_q[1] <= duty_buf1;
      end
    end
  end

  // ****************************************
  // Control and fault registers
  // ****************************************
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_location_select_q <= CTRL_ONE_RESET[CTL1_FAULT_LOCATION_SELECT_BIT];
      reload_irq_enable_q <= CTRL_ONE_RESET[CTL1_RIRQ_BIT];
      reload_flag_q <= CTRL_ONE_RESET[CTL1_RFLAG_BIT];
      load_ok_q <= CTRL_ONE_RESET[CTL1_LOAD_OK_BIT];
      generator_enable_q <= CTRL_ONE_RESET[CTL1_EN_BIT];
      flag_read_armed_q <= 1'b0;
      load_ok_read_zero_q <= 1'b0;
      ctrl_two_q <= CTRL_TWO_RESET;
    end else begin
      if (wr_ctl1) begin
        fault_location_select_q <= wdata_in[CTL1_FAULT_LOCATION_SELECT_BIT];
        reload_irq_enable_q <= wdata_in[CTL1_RIRQ_BIT];
        generator_enable_q <= wdata_in[CTL1_EN_BIT]; // R11
      end
      if (wr_ctl2) begin
        ctrl_two_q <= wdata_in;
      end
      // Set wins over clear; a reload after the read voids the clear
      if (reload) begin
        reload_flag_q <= 1'b1; // R7
      end else if (wr_ctl1 && !wdata_in[CTL1_RFLAG_BIT] && flag_read_armed_q) begin
        reload_flag_q <= 1'b0; // R8
      end
      if (reload) begin
        flag_read_armed_q <= 1'b0;
      end else if (rd_ctl1) begin
        flag_read_armed_q <= reload_flag_q;
      end
      // Load-ok only sets after a read that saw it clear
      if (commit) begin
        load_ok_q <= 1'b0; // R9
      end else if (wr_ctl1) begin
        load_ok_q <= wdata_in[CTL1_LOAD_OK_BIT] ? (load_ok_q || load_ok_read_zero_q) : 1'b0;
      end
      if (rd_ctl1) begin
        load_ok_read_zero_q <= !load_ok_q;
      end else if (wr_ctl1) begin
        load_ok_read_zero_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_map_q <= FAULT_MAP_RESET[1:0];
      map_written_q <= 1'b0;
      fault_irq_enable_q <= FAULT_CTRL_RESET[FCTL_IRQ_BIT];
      fault_reenable_mode_q <= FAULT_CTRL_RESET[FCTL_MODE_BIT];
      fault_prev_q <= 1'b0;
      fault_event_flag_q <= 1'b0;
      fault_irq_latch_q <= 1'b0;
    end else begin
      // Only the first map write after reset lands
      if (wr_map && !map_written_q) begin
        fault_map_q <= wdata_in[1:0]; // R17
        map_written_q <= 1'b1;
      end
      if (wr_fctl) begin
        fault_irq_enable_q <= wdata_in[FCTL_IRQ_BIT];
        fault_reenable_mode_q <= wdata_in[FCTL_MODE_BIT]; // R20
      end
      fault_prev_q <= fault_level;
      if (fault_rise) begin
        fault_event_flag_q <= 1'b1; // R22
      end else if (wr_ack) begin
        fault_event_flag_q <= 1'b0;
      end
      // A same-cycle enable clear beats a rising fault, so the latch stays clear
      if (fault_rise && fault_irq_enable_q && !(wr_fctl && !wdata_in[FCTL_IRQ_BIT])) begin
        fault_irq_latch_q <= 1'b1; // R25
      end else if (wr_ack || (wr_fctl && !wdata_in[FCTL_IRQ_BIT])) begin
        fault_irq_latch_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Per-channel output stage
  // ****************************************
  wire [1:0] soft_dis = {ctrl_two_q[CTL2_SOFT_DISABLE_CH1_BIT], ctrl_two_q[CTL2_SOFT_DISABLE_CH0_BIT]};
  wire [1:0] polarity = {ctrl_two_q[CTL2_POLARITY_CH1_BIT], ctrl_two_q[CTL2_POLARITY_CH0_BIT]};
  // Fault may clear only at a cycle start with the input low; manual mode also needs the flag acknowledged
  wire fault_release = cycle_start && !fault_level && (fault_reenable_mode_q || !fault_event_flag_q); // R23 R24
  logic [1:0] active, pwm_d, oe_n_d;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      wire signed [15:0] duty = duty_act_q[ch];
      wire at_full = duty >= $signed({4'h0, mod_act_q});
      assign active[ch] = (duty <= 16'sh0000) ? 1'b0 : // R2
                          at_full ? 1'b1 : // R3
                          ({4'h0, count_q} < duty_act_q[ch]); // R27
      always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
          fault_block_q[ch] <= 1'b0;
          soft_block_q[ch] <= 1'b0;
        end else begin
          if (fault_level && fault_map_q[ch]) begin
            fault_block_q[ch] <= 1'b1; // R18 R19
          end else if (fault_release) begin
            fault_block_q[ch] <= 1'b0;
          end
          // A cleared disable bit releases the pin only at the next cycle start
          if (soft_dis[ch]) begin
            soft_block_q[ch] <= 1'b1; // R14
          end else if (cycle_start) begin
            soft_block_q[ch] <= 1'b0;
          end
        end
      end
      // Blocked outputs drive the inactive level; the generator output is forced low when off
      wire on = generator_enable_q && active[ch] && !fault_block_q[ch] && !soft_block_q[ch]
                && !(fault_level && fault_map_q[ch]) && !soft_dis[ch];
      assign pwm_d[ch] = generator_enable_q && (polarity[ch] ? on : !on); // R15
      assign oe_n_d[ch] = !generator_enable_q; // R11
    end
  endgenerate

  // ****************************************
  // Read mux and outputs
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_in)
      // Buffer bytes come from the flat copy so the read data leave a single flop
      ADDR_DUTY0_HIGH: rd_mux = buf_all[7:0]; // R4
      ADDR_DUTY0_LOW: rd_mux = buf_all[15:8];
      ADDR_DUTY1_HIGH: rd_mux = buf_all[23:16];
      ADDR_DUTY1_LOW: rd_mux = buf_all[31:24];
      ADDR_MOD_HIGH: rd_mux = {4'h0, buf_all[35:32]};
      ADDR_MOD_LOW: rd_mux = buf_all[47:40];
      ADDR_CTRL_ONE: rd_mux = {fault_location_select_q, 1'b0, reload_irq_enable_q, reload_flag_q, 2'b00,
                               load_ok_q, generator_enable_q};
      ADDR_CTRL_TWO: rd_mux = ctrl_two_q; // R4
      ADDR_FAULT_MAP: rd_mux = {6'h00, fault_map_q};
      ADDR_FAULT_CTRL: rd_mux = {6'h00, fault_irq_enable_q, fault_reenable_mode_q};
      ADDR_FAULT_STAT: rd_mux = {6'h00, fault_level, fault_event_flag_q}; // R21
      // Reading the high byte freezes the low byte until it is read
      ADDR_COUNT_HIGH: rd_mux = {4'h0, count_q[11:8]};
      ADDR_COUNT_LOW: rd_mux = count_low_latch_sel_q ? count_low_latch_q : count_q[7:0];
      // Unmapped addresses and the acknowledge register read as zero
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
      count_low_latch_q <= 8'h00;
      count_low_latch_sel_q <= 1'b0;
      pwm_q <= 2'b00;
      oe_n_q <= 2'b11;
      reload_irq_q <= 1'b0;
      fault_irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_in ? rd_mux : 8'h00;
      if (rd_in && addr_in == ADDR_COUNT_HIGH) begin
        count_low_latch_q <= count_q[7:0];
        count_low_latch_sel_q <= 1'b1;
      end else if (rd_in && addr_in == ADDR_COUNT_LOW) begin
        count_low_latch_sel_q <= 1'b0;
      end
      pwm_q <= pwm_d;
      oe_n_q <= oe_n_d;
      // Clearing either the flag or the enable drops the request one cycle later
      reload_irq_q <= reload_irq_enable_q && reload_flag_q; // R6
      fault_irq_q <= fault_irq_latch_q;
    end
  end

  assign rdata_out = rdata_q;
  assign pwm_out = pwm_q;
  assign pwm_oe_n_out = oe_n_q;
  assign reload_irq_out = reload_irq_q;
  assign fault_irq_out = fault_irq_q;
endmodule // pwm_fault_top

// ===== testbench/pwm_fault_monitor.sv
// Port-level assertions for the two-channel PWM block
`timescale 1ns/10ps
module pwm_fault_monitor
  import pwm_fault_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic port_b_bit2_in,
  input wire logic port_b_bit7_in,
  input wire logic [1:0] pwm_out,
  input wire logic [1:0] pwm_oe_n_out,
  input wire logic reload_irq_out,
  input wire logic fault_irq_out
);
  wire c1_wr = wr_in && addr_in == ADDR_CTRL_ONE;
  wire c2_wr = wr_in && addr_in == ADDR_CTRL_TWO;
  wire fc_wr = wr_in && addr_in == ADDR_FAULT_CTRL;
  wire ack_wr = wr_in && addr_in == ADDR_FAULT_ACK && wdata_in[FACK_BIT];
  wire pins_low = !port_b_bit2_in && !port_b_bit7_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  chk_ack_reads_zero: assert property (rd_in && addr_in == ADDR_FAULT_ACK |=> rdata_out == 8'h00)
    else $error("ack register read not zero");
  chk_off_hiz: assert property (c1_wr && !wdata_in[CTL1_EN_BIT] |=> ##1 pwm_oe_n_out == 2'b11)
    else $error("outputs not released after disable");
  chk_on_drive: assert property (c1_wr && wdata_in[CTL1_EN_BIT] ##1 !c1_wr |=> pwm_oe_n_out == 2'b00)
    else $error("outputs not driven after enable");
  chk_reload_gate: assert property (c1_wr && !wdata_in[CTL1_RIRQ_BIT] ##1 !c1_wr |=> !reload_irq_out)
    else $error("reload interrupt while its enable is clear");
  chk_fault_gate: assert property (fc_wr && !wdata_in[FCTL_IRQ_BIT] ##1 !fc_wr |=> !fault_irq_out)
    else $error("fault interrupt while its enable is clear");
  chk_ack_clears: assert property ($past(pins_low) && pins_low && ack_wr ##1 pins_low |=> !fault_irq_out)
    else $error("fault interrupt kept after acknowledge");
  chk_level_read: assert property (rd_in && addr_in == ADDR_FAULT_STAT && port_b_bit2_in == port_b_bit7_in
    && $stable(port_b_bit2_in) && $stable(port_b_bit7_in)
    |=> rdata_out[FSTAT_LEVEL_BIT] == $past(port_b_bit2_in))
    else $error("status level differs from fault input");
  chk_soft_off: assert property (c2_wr && wdata_in[CTL2_SOFT_DISABLE_CH0_BIT] ##1 !c2_wr
    |=> pwm_oe_n_out[0] || pwm_out[0] == !$past(wdata_in[CTL2_POLARITY_CH0_BIT], 2))
    else $error("disabled channel not at inactive level");
endmodule // pwm_fault_monitor

bind pwm_fault_top pwm_fault_monitor u_monitor (.clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .port_b_bit2_in, .port_b_bit7_in, .pwm_out, .pwm_oe_n_out, .reload_irq_out, .fault_irq_out);

// ===== testbench/pwm_stage_model.sv
// Far-side model: power stage pins and the two fault sources
`timescale 1ns/10ps
module pwm_stage_model (
  input wire logic clock_in,
  input wire logic [1:0] pwm_in,
  input wire logic [1:0] oe_n_in,
  input wire logic [1:0] fault_cmd_in,
  output logic [1:0] pin_out,
  output logic port_b_bit2_out,
  output logic port_b_bit7_out
);
  logic [1:0] last_q = 2'b00;
  // No pull on the stage input: a released pin toggles so it never reads as a clean level
  always_ff @(posedge clock_in) begin
    last_q <= pin_out;
  end
  assign pin_out = (~oe_n_in & pwm_in) | (oe_n_in & ~last_q);
  assign port_b_bit2_out = fault_cmd_in[0];
  assign port_b_bit7_out = fault_cmd_in[1];
endmodule // pwm_stage_model

// ===== testbench/test_two_channel_pwm_fault_regs.sv
// Self-checking testbench for the two-channel PWM block with fault input
`timescale 1ns/10ps
`define CK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module test_two_channel_pwm_fault_regs
  import pwm_fault_pkg::*;
;
  logic clock_in = 1'b0;
  logic rstn_in, wr_in, rd_in, port_b_bit2_in, port_b_bit7_in, reload_irq_out, fault_irq_out;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, v;
  logic [1:0] pwm_out, pwm_oe_n_out, fault_cmd, pin;
  int check_count, bad_count, cyc, g;
  pwm_fault_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .port_b_bit2_in(port_b_bit2_in),
    .port_b_bit7_in(port_b_bit7_in), .pwm_out(pwm_out), .pwm_oe_n_out(pwm_oe_n_out),
    .reload_irq_out(reload_irq_out), .fault_irq_out(fault_irq_out));
  pwm_stage_model u_stage (.clock_in(clock_in), .pwm_in(pwm_out), .oe_n_in(pwm_oe_n_out),
    .fault_cmd_in(fault_cmd), .pin_out(pin), .port_b_bit2_out(port_b_bit2_in), .port_b_bit7_out(port_b_bit7_in));
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A gap cycle after each write keeps the strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
    d = rdata_out;
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CK(nm, e, d)
  endtask
  // Read zero then write one: commit buffers, keep enable, location and reload irq
  task automatic ld(input int w);
    rd(ADDR_CTRL_ONE, v);
    wr(ADDR_CTRL_ONE, 8'ha3);
    repeat (w) @(posedge clock_in);
  endtask
  task automatic pw(input string nm, input int ch, input int n, input int ehi, input int eri);
    int hi, ris;
    logic p;
    hi = 0;
    ris = 0;
    repeat (10) @(posedge clock_in);
    p = pin[ch];
    repeat (n) begin
      @(posedge clock_in);
      hi += int'(pin[ch]);
      ris += int'(pin[ch] && !p);
      p = pin[ch];
    end
    if (ehi >= 0) `CK(nm, ehi, hi)
    `CK(nm, eri, ris)
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (reload_irq_out !== 1'b1 && n < 300) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  // Clear the reload flag; retry if a reload lands between the read and the write
  task automatic clr_flag();
    do begin
      rd(ADDR_CTRL_ONE, v);
      wr(ADDR_CTRL_ONE, 8'ha1);
      @(posedge clock_in);
    end while (reload_irq_out !== 1'b0);
  endtask
  // Cycles between two fresh reload interrupts; the extra edge lets the interrupt drop first
  task automatic gap(output int gp);
    int t;
    clr_flag();
    wait_irq();
    t = cyc;
    clr_flag();
    wait_irq();
    gp = cyc - t;
  endtask
  initial begin
    rstn_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    fault_cmd = 2'b00;
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rc("ctrl1", ADDR_CTRL_ONE, CTRL_ONE_RESET);
    rc("ctrl2", ADDR_CTRL_TWO, CTRL_TWO_RESET);
    rc("fstat", ADDR_FAULT_STAT, 8'h00);
    rc("unmapped", 4'he, 8'h00);
    wr(ADDR_CTRL_TWO, 8'hcf);
    rc("ctrl2_buf", ADDR_CTRL_TWO, 8'hcf);
    wr(ADDR_CTRL_TWO, 8'h0c);
    wr(ADDR_DUTY0_LOW, 8'h02);
    wr(ADDR_DUTY1_HIGH, 8'h7f);
    wr(ADDR_DUTY1_LOW, 8'hff);
    wr(ADDR_MOD_LOW, 8'h08);
    wr(ADDR_FAULT_MAP, 8'h01);
    wr(ADDR_FAULT_MAP, 8'h03);
    rc("map_once", ADDR_FAULT_MAP, 8'h01);
    wr(ADDR_FAULT_CTRL, 8'h03);
    rc("fctl", ADDR_FAULT_CTRL, 8'h03);
    $display("test registers done");
    ld(20);
    pw("duty_mid", 0, 16, 4, 2);
    pw("duty_full", 1, 16, 16, 0);
    rc("load_ok_clear", ADDR_CTRL_ONE, 8'hb1);
    `CK("reload_irq", 1'b1, reload_irq_out)
    wr(ADDR_DUTY1_HIGH, 8'h80);
    pw("no_commit", 1, 16, 16, 0);
    rc("duty_buf", ADDR_DUTY1_HIGH, 8'h80);
    ld(20);
    pw("duty_neg", 1, 16, 0, 0);
    wr(ADDR_DUTY1_HIGH, 8'h00);
    wr(ADDR_DUTY1_LOW, 8'h04);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL_TWO, 8'h0c | p[7:0]);
      ld(140);
      pw("prescale", 0, 64, -1, 8 >> p);
    end
    $display("test duty done");
    wr(ADDR_CTRL_TWO, 8'h0c);
    ld(140);
    for (int q = 0; q < 4; q++) begin
      wr(ADDR_CTRL_TWO, {q[1:0], 6'h0c});
      gap(g);
      gap(g);
      `CK("reload_gap", 8 << q, g)
    end
    wr(ADDR_CTRL_TWO, 8'h0c);
    gap(g);
    rd(ADDR_CTRL_ONE, v);
    repeat (10) @(posedge clock_in);
    wr(ADDR_CTRL_ONE, 8'ha1);
    rc("flag_kept", ADDR_CTRL_ONE, 8'hb1);
    wr(ADDR_CTRL_ONE, 8'h91);
    @(posedge clock_in);
    `CK("irq_off", 1'b0, reload_irq_out)
    rc("flag_stays", ADDR_CTRL_ONE, 8'h91);
    wr(ADDR_CTRL_ONE, 8'ha1);
    wr(ADDR_CTRL_TWO, 8'h1c);
    pw("soft_off", 0, 16, 0, 0);
    wr(ADDR_CTRL_TWO, 8'h08);
    pw("neg_pol", 0, 16, 12, 2);
    wr(ADDR_CTRL_TWO, 8'h0c);
    $display("test reload done");
    fault_cmd <= 2'b10;
    repeat (3) @(posedge clock_in);
    rc("other_pin", ADDR_FAULT_STAT, 8'h00);
    fault_cmd <= 2'b01;
    repeat (3) @(posedge clock_in);
    rc("fault_seen", ADDR_FAULT_STAT, 8'h03);
    `CK("fault_irq", 1'b1, fault_irq_out)
    pw("fault_off", 0, 16, 0, 0);
    pw("unmapped_ch", 1, 16, 8, 2);
    wr(ADDR_FAULT_ACK, 8'h00);
    rc("ack_zero", ADDR_FAULT_STAT, 8'h03);
    fault_cmd <= 2'b00;
    pw("auto_back", 0, 16, 4, 2);
    wr(ADDR_FAULT_ACK, 8'h01);
    rc("flag_clr", ADDR_FAULT_STAT, 8'h00);
    rc("ack_read", ADDR_FAULT_ACK, 8'h00);
    `CK("fault_irq_clr", 1'b0, fault_irq_out)
    wr(ADDR_FAULT_CTRL, 8'h00);
    fault_cmd <= 2'b01;
    pw("gated_off", 0, 16, 0, 0);
    `CK("irq_gated", 1'b0, fault_irq_out)
    fault_cmd <= 2'b00;
    pw("manual_held", 0, 24, 0, 0);
    wr(ADDR_FAULT_ACK, 8'h01);
    pw("manual_back", 0, 16, 4, 2);
    wr(ADDR_CTRL_ONE, 8'h21);
    fault_cmd <= 2'b10;
    repeat (3) @(posedge clock_in);
    rc("pos_low", ADDR_FAULT_STAT, 8'h03);
    $display("test fault done");
    wr(ADDR_CTRL_ONE, 8'h00);
    repeat (2) @(posedge clock_in);
    `CK("released", 2'b11, pwm_oe_n_out)
    $display("test disable done");
    end_sim();
  end
endmodule // test_two_channel_pwm_fault_regs
